/* File: rtl/dtf_consts.svh */
// Purpose: Named constants of the disk track formatter
// Assumes: Included by bare name wherever needed
// Notes: Counts are bytes on the track
`ifndef DTF_CONSTS_SVH
`define DTF_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define DTF_A_CTRL 8'h00
`define DTF_A_STAT 8'h04
`define DTF_A_TRKA 8'h08
`define DTF_A_TRKB 8'h0c
`define DTF_A_BUFL 8'h10
`define DTF_A_IDW 8'h14
// ****************************************
// Control and status bits
// ****************************************
`define DTF_C_INIT 0
`define DTF_C_START 1
`define DTF_C_DD 2
`define DTF_C_HARD 3
`define DTF_C_HSEC 4
`define DTF_S_DONE 2
// ****************************************
// Byte patterns
// ****************************************
`define DTF_FF 8'hff
`define DTF_ZERO 8'h00
`define DTF_GAP_DD 8'h4e
`define DTF_IMK_FM 8'hfc
`define DTF_IMK_FM_CLK 8'hd7
`define DTF_IDMK_FM 8'hfe
`define DTF_DMK_FM 8'hfb
`define DTF_MK_FM_CLK 8'hc7
`define DTF_IMK_DD 8'hc2
`define DTF_MK_DD 8'ha1
`define DTF_FLG_IDX 8'hfc
`define DTF_FLG_ID 8'hfe
`define DTF_FLG_DAT 8'hfb
`define DTF_SUP34 8'hf7
`define DTF_SUP45 8'hef
`define DTF_CRC_INIT 16'hffff
`define DTF_CRC_POLY 16'h1021
`define DTF_SEC_BASE 16'h0080
// ****************************************
// Built-in field counts
// ****************************************
`define DTF_PREG_FM 16'd40
`define DTF_PREG_DD 16'd80
`define DTF_SYNC_FM 16'd6
`define DTF_SYNC_DD 16'd12
`define DTF_MKS_FM 16'd1
`define DTF_MKS_DD 16'd3
`define DTF_PIG_FM 16'd26
`define DTF_PIG_DD 16'd50
`define DTF_PIG_HD 16'd20
`define DTF_PIDG_FM 16'd11
`define DTF_PIDG_DD 16'd22
`define DTF_PIDG_HD 16'd3
`define DTF_IDB_FL 16'd4
`define DTF_IDB_HD 16'd5
`define DTF_CRC_LEN 16'd2
`define DTF_ONE 16'd1
`endif

/* File: rtl/dtf_formatter.sv */
// Purpose: Track format writer with APB registers
// Assumes: Drive pins are asynchronous to REF_CLK
// Notes: One byte is written per rising edge of BYTE_REQ
`timescale 1ns/1ps
`default_nettype none
`include "dtf_consts.svh"
// Summary of operation
// - Single-density marks carry own clock; others FF
// - Double-density index mark drops clock 3-4
// - Double-density ID/data marks drop clock 4-5
// - Format runs index edge to index edge
// - Buffer length ends the sectors; tail gap then runs to the index
// - Sector holds 128 times 2^n bytes
// - Sync, mark and gap counts built in, except the host-loaded post-data gap
// - Format words: length code high, fill low
// - One, three or one marks by format
// - Hard-sectored waits sector pulse each sector
// - Double density: flag byte follows marks
// - ID and data subfields: marks, bytes, generated check pattern
// - One index subfield before first sector, none when hard-sectored
// - No commands before reset and host setup
// - Reset clears state, write pins released
// - Sequencer idles until host initialization
module dtf_formatter (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic INDEX_PULSE,
    input wire logic SECTOR_PULSE,
    input wire logic BYTE_REQ,
    output logic [7:0] WR_DATA,
    output logic [7:0] WR_CLK,
    output logic WR_STROBE,
    output logic WR_OE
);
    // ****************************************
    // Registers and APB decode
    // ****************************************
    logic [4:0] ctrl;
    logic done;
    logic [31:0] trka, trkb, idw;
    logic [15:0] bufl;
    wire acc = PSEL & PENABLE;
    wire wr = acc & PWRITE;
    wire hit_ctrl = PADDR == `DTF_A_CTRL;
    wire hit_stat = PADDR == `DTF_A_STAT;
    wire hit_trka = PADDR == `DTF_A_TRKA;
    wire hit_trkb = PADDR == `DTF_A_TRKB;
    wire hit_bufl = PADDR == `DTF_A_BUFL;
    wire hit_idw = PADDR == `DTF_A_IDW;
    wire mapped = hit_ctrl | hit_stat | hit_trka | hit_trkb | hit_bufl | hit_idw;
    wire start_cmd = wr & hit_ctrl & PWDATA[`DTF_C_START];
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~mapped;
    dtf_pkg::dtf_state_e state, next_state;
    logic [15:0] cnt, sec_cnt;
    logic [31:0] rd_mux;
    assign rd_mux = hit_ctrl ? {27'h0, ctrl[4:2], 1'b0, ctrl[0]} :
                    hit_stat ? {sec_cnt, 3'h0, state, 5'h0, done,
                                state != dtf_pkg::ST_IDLE && state != dtf_pkg::ST_UNINIT, ctrl[0]} :
                    hit_trka ? trka : hit_trkb ? trkb :
                    hit_bufl ? {16'h0, bufl} : hit_idw ? idw : 32'h0;
    // Read data captured in setup, so access never waits
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
            PRDATA <= 32'h0;
        else if (PSEL & ~PENABLE & ~PWRITE)
            PRDATA <= rd_mux;
    // Host writes; every register clears on reset
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            ctrl <= 5'h0;
            trka <= 32'h0;
            trkb <= 32'h0;
            bufl <= 16'h0;
            idw <= 32'h0;
        end
        else if (wr)
        begin
            if (hit_ctrl) ctrl <= {PWDATA[4:2], 1'b0, PWDATA[0]};
            if (hit_trka) trka <= PWDATA;
            if (hit_trkb) trkb <= PWDATA;
            if (hit_bufl) bufl <= PWDATA[15:0];
            if (hit_idw) idw <= PWDATA;
        end
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] s1, s2, s3;
    // Third stage only feeds the edge detectors
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            s3 <= 3'h0;
        end
        else
        begin
            s1 <= {BYTE_REQ, SECTOR_PULSE, INDEX_PULSE};
            s2 <= s1;
            s3 <= s2;
        end
    wire idx_rise = s2[0] & ~s3[0];
    wire sec_rise = s2[1] & ~s3[1];
    wire tick = s2[2] & ~s3[2];
    // ****************************************
    // Working copy of the format fields
    // ****************************************
    logic w_dd, w_hard, w_hsec;
    logic [7:0] w_n4, w_code, w_fill;
    logic [15:0] w_bufl;
    logic [31:0] w_id;
    wire fm = ~w_dd;
    wire one_mark = fm | w_hard;
    wire [15:0] sec_len = `DTF_SEC_BASE << w_code[2:0];
    // latch fields once, on the accepted start
    // unused gap words are never copied
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            {w_dd, w_hard, w_hsec} <= 3'h0;
            {w_n4, w_code, w_fill} <= 24'h0;
            w_bufl <= 16'h0;
            w_id <= 32'h0;
        end
        else if (state == dtf_pkg::ST_IDLE && start_cmd)
        begin
            w_dd <= PWDATA[`DTF_C_DD] | PWDATA[`DTF_C_HARD];
            w_hard <= PWDATA[`DTF_C_HARD];
            w_hsec <= PWDATA[`DTF_C_HARD] & PWDATA[`DTF_C_HSEC];
            // upper word of TRKB is N4/N5, lower code/fill
            w_n4 <= trkb[31:24];
            w_code <= trkb[15:8];
            w_fill <= trkb[7:0];
            w_bufl <= bufl;
            w_id <= idw;
        end
    // ****************************************
    // Segment table
    // ****************************************
    logic [15:0] seg_len;
    logic [7:0] seg_data, seg_clk, gap, id_byte;
    dtf_pkg::dtf_state_e seg_next;
    logic [15:0] crc;
    logic [2:0] id_ix;
    wire sec_end = sec_cnt + `DTF_ONE >= w_bufl;
    wire after_gap = w_hsec;
    assign gap = fm ? `DTF_FF : `DTF_GAP_DD;
    assign id_ix = w_hard ? cnt[2:0] : cnt[2:0] + 3'h1;
    // Sector numbers count up from the first one given
    always_comb
        case (id_ix)
            3'h0: id_byte = w_id[15:8];
            3'h1: id_byte = w_id[7:0];
            3'h2: id_byte = w_id[23:16];
            3'h3: id_byte = w_id[31:24] + sec_cnt[7:0];
            default: id_byte = w_code;
        endcase
    always_comb
    begin
        seg_len = `DTF_ONE;
        seg_data = gap;
        seg_clk = `DTF_FF;
        seg_next = dtf_pkg::ST_IDLE;
        case (state)
            dtf_pkg::ST_PREG:
            begin
                seg_len = fm ? `DTF_PREG_FM : `DTF_PREG_DD;
                seg_next = dtf_pkg::ST_ISYNC;
            end
            dtf_pkg::ST_ISYNC:
            begin
                seg_len = fm ? `DTF_SYNC_FM : `DTF_SYNC_DD;
                seg_data = `DTF_ZERO;
                seg_next = dtf_pkg::ST_IMARK;
            end
            dtf_pkg::ST_IMARK:
            begin
                seg_len = fm ? `DTF_MKS_FM : `DTF_MKS_DD;
                seg_data = fm ? `DTF_IMK_FM : `DTF_IMK_DD;
                seg_clk = fm ? `DTF_IMK_FM_CLK : `DTF_SUP34;
                seg_next = fm ? dtf_pkg::ST_POSTIG : dtf_pkg::ST_IFLAG;
            end
            dtf_pkg::ST_IFLAG:
            begin
                seg_data = `DTF_FLG_IDX;
                seg_next = dtf_pkg::ST_POSTIG;
            end
            dtf_pkg::ST_POSTIG:
            begin
                seg_len = w_hard ? `DTF_PIG_HD : fm ? `DTF_PIG_FM : `DTF_PIG_DD;
                seg_next = after_gap ? dtf_pkg::ST_WAIT_SEC : dtf_pkg::ST_SYNC;
            end
            dtf_pkg::ST_SYNC, dtf_pkg::ST_DSYNC:
            begin
                seg_len = fm ? `DTF_SYNC_FM : `DTF_SYNC_DD;
                seg_data = `DTF_ZERO;
                seg_next = state == dtf_pkg::ST_SYNC ? dtf_pkg::ST_IDMK : dtf_pkg::ST_DMK;
            end
            dtf_pkg::ST_IDMK, dtf_pkg::ST_DMK:
            begin
                seg_len = one_mark ? `DTF_MKS_FM : `DTF_MKS_DD;
                seg_data = !fm ? `DTF_MK_DD : state == dtf_pkg::ST_IDMK ? `DTF_IDMK_FM : `DTF_DMK_FM;
                seg_clk = fm ? `DTF_MK_FM_CLK : `DTF_SUP45;
                seg_next = state == dtf_pkg::ST_IDMK ? (fm ? dtf_pkg::ST_IDB : dtf_pkg::ST_IDFLG)
                                                     : (fm ? dtf_pkg::ST_FILL : dtf_pkg::ST_DFLG);
            end
            dtf_pkg::ST_IDFLG:
            begin
                seg_data = `DTF_FLG_ID;
                seg_next = dtf_pkg::ST_IDB;
            end
            dtf_pkg::ST_IDB:
            begin
                seg_len = w_hard ? `DTF_IDB_HD : `DTF_IDB_FL;
                seg_data = id_byte;
                seg_next = dtf_pkg::ST_ICRC;
            end
            dtf_pkg::ST_ICRC, dtf_pkg::ST_DCRC:
            begin
                seg_len = `DTF_CRC_LEN;
                seg_data = cnt[0] ? crc[7:0] : crc[15:8];
                seg_next = state == dtf_pkg::ST_ICRC ? dtf_pkg::ST_PIDG : dtf_pkg::ST_PDG;
            end
            dtf_pkg::ST_PIDG:
            begin
                seg_len = w_hard ? `DTF_PIDG_HD : fm ? `DTF_PIDG_FM : `DTF_PIDG_DD;
                seg_data = w_hard ? `DTF_ZERO : gap;
                seg_next = dtf_pkg::ST_DSYNC;
            end
            dtf_pkg::ST_DFLG:
            begin
                seg_data = `DTF_FLG_DAT;
                seg_next = dtf_pkg::ST_FILL;
            end
            // data part is fill bytes of full sector size
            dtf_pkg::ST_FILL:
            begin
                seg_len = sec_len;
                seg_data = w_fill;
                seg_next = dtf_pkg::ST_DCRC;
            end
            // gap length is whatever the host loaded
            dtf_pkg::ST_PDG:
            begin
                seg_len = {8'h0, w_n4};
                seg_next = sec_end ? dtf_pkg::ST_TAIL :
                           after_gap ? dtf_pkg::ST_WAIT_SEC : dtf_pkg::ST_SYNC;
            end
            dtf_pkg::ST_TAIL:
            begin
                seg_len = 16'hffff;
                seg_next = dtf_pkg::ST_TAIL;
            end
            default: seg_next = dtf_pkg::ST_IDLE;
        endcase
    end
    // ****************************************
    // Sequencer
    // ****************************************
    wire parked = state == dtf_pkg::ST_UNINIT || state == dtf_pkg::ST_IDLE ||
                  state == dtf_pkg::ST_WAIT_IDX || state == dtf_pkg::ST_WAIT_SEC;
    wire run = state != dtf_pkg::ST_UNINIT && state != dtf_pkg::ST_IDLE &&
               state != dtf_pkg::ST_WAIT_IDX;
    wire emit = tick & ~parked;
    wire last = cnt + `DTF_ONE >= seg_len;
    // commands wait for init; track order
    always_comb
    begin
        next_state = state;
        case (state)
            dtf_pkg::ST_UNINIT: if (ctrl[`DTF_C_INIT]) next_state = dtf_pkg::ST_IDLE;
            dtf_pkg::ST_IDLE: if (start_cmd) next_state = dtf_pkg::ST_WAIT_IDX;
            dtf_pkg::ST_WAIT_IDX:
                if (idx_rise) next_state = w_hard ? dtf_pkg::ST_POSTIG : dtf_pkg::ST_PREG;
            dtf_pkg::ST_WAIT_SEC:
                if (idx_rise) next_state = dtf_pkg::ST_IDLE;
                else if (sec_rise) next_state = dtf_pkg::ST_SYNC;
            default:
                if (idx_rise) next_state = dtf_pkg::ST_IDLE;
                else if (emit && last) next_state = seg_next;
        endcase
    end
    // Byte counter restarts on every segment change
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            state <= dtf_pkg::ST_UNINIT;
            cnt <= 16'h0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_state != state ? 16'h0 : emit ? cnt + `DTF_ONE : cnt;
        end
    // sectors counted against the buffer length
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
            sec_cnt <= 16'h0;
        else if (state == dtf_pkg::ST_WAIT_IDX)
            sec_cnt <= 16'h0;
        else if (state == dtf_pkg::ST_PDG && emit && last)
            sec_cnt <= sec_cnt + `DTF_ONE;
    // Done is sticky; a new end beats a host clear
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
            done <= 1'b0;
        else if (run && idx_rise)
            done <= 1'b1;
        else if (wr && hit_stat && PWDATA[`DTF_S_DONE])
            done <= 1'b0;
    // ****************************************
    // Check pattern and byte output
    // ****************************************
    function automatic logic [15:0] dtf_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `DTF_CRC_POLY : 16'h0);
        return r;
    endfunction : dtf_crc_byte
    wire crc_clr = state == dtf_pkg::ST_SYNC || state == dtf_pkg::ST_DSYNC;
    wire crc_on = state inside {dtf_pkg::ST_IDMK, dtf_pkg::ST_IDFLG, dtf_pkg::ST_IDB,
                                dtf_pkg::ST_DMK, dtf_pkg::ST_DFLG, dtf_pkg::ST_FILL};
    // check covers marks, flag and bytes of a subfield
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
            crc <= `DTF_CRC_INIT;
        else if (crc_clr)
            crc <= `DTF_CRC_INIT;
        else if (emit && crc_on)
            crc <= dtf_crc_byte(crc, seg_data);
    dtf_pkg::dtf_state_e out_st;
    always_ff @(posedge REF_CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            WR_DATA <= 8'h0;
            WR_CLK <= 8'h0;
            WR_STROBE <= 1'b0;
            WR_OE <= 1'b0;
            out_st <= dtf_pkg::ST_UNINIT;
        end
        else
        begin
            WR_STROBE <= emit;
            WR_OE <= run && !(idx_rise && next_state == dtf_pkg::ST_IDLE);
            if (emit)
            begin
                WR_DATA <= seg_data;
                WR_CLK <= seg_clk;
                out_st <= state;
            end
        end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking dtf_cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    sequence dtf_mark_out;
        WR_STROBE && (out_st == dtf_pkg::ST_IDMK || out_st == dtf_pkg::ST_DMK);
    endsequence
    AST_NOCMD_BEFORE_INIT: assert property (state == dtf_pkg::ST_UNINIT && start_cmd
        |=> state != dtf_pkg::ST_WAIT_IDX) else $error("command taken before init");
    AST_IDLE_LOOP: assert property (state == dtf_pkg::ST_UNINIT && !ctrl[0]
        |=> state == dtf_pkg::ST_UNINIT) else $error("left idle loop uninitialised");
    AST_PINS_RELEASED: assert property (!run |=> !WR_OE) else $error("pins driven while idle");
    AST_FM_PLAIN_CLK: assert property (WR_STROBE && !w_dd && WR_CLK != `DTF_IMK_FM_CLK
        && WR_CLK != `DTF_MK_FM_CLK |-> WR_CLK == `DTF_FF) else $error("bad single-density clock");
    AST_IDX_MARK_CLK: assert property (WR_STROBE && w_dd && out_st == dtf_pkg::ST_IMARK
        |-> WR_CLK == `DTF_SUP34 && WR_DATA == `DTF_IMK_DD) else $error("index mark clock wrong");
    AST_ID_MARK_CLK: assert property (dtf_mark_out and w_dd
        |-> WR_CLK == `DTF_SUP45) else $error("address mark clock wrong");
    AST_STOP_AT_INDEX: assert property (run && idx_rise
        |=> state == dtf_pkg::ST_IDLE ##1 !WR_OE) else $error("write did not stop at index");
    AST_TAIL_COUNT: assert property (state == dtf_pkg::ST_TAIL
        |-> sec_cnt >= w_bufl) else $error("ended before buffer length");
    AST_SECTOR_SIZE: assert property (state == dtf_pkg::ST_FILL
        |-> cnt < (`DTF_SEC_BASE << w_code[2:0])) else $error("sector overran size");
    AST_SECTOR_WAIT: assert property (state == dtf_pkg::ST_WAIT_SEC && !sec_rise && !idx_rise
        |=> state == dtf_pkg::ST_WAIT_SEC && !WR_STROBE) else $error("sector pulse skipped");
    AST_FIELDS_FROZEN: assert property (run ##1 run
        |-> $stable(w_n4) && $stable(w_fill) && $stable(w_bufl)) else $error("fields changed in run");
endmodule : dtf_formatter
`default_nettype wire

/* File: rtl/dtf_pkg.sv */
// Purpose: Types of the disk track formatter
// Assumes: Used with scoped names only
// Notes: Gray codes follow the track order
package dtf_pkg;
    typedef enum logic [4:0] {
        ST_UNINIT = 5'h00, ST_IDLE = 5'h01, ST_WAIT_IDX = 5'h03,
        ST_PREG = 5'h02, ST_ISYNC = 5'h06, ST_IMARK = 5'h07,
        ST_IFLAG = 5'h05, ST_POSTIG = 5'h04, ST_WAIT_SEC = 5'h0c,
        ST_SYNC = 5'h0d, ST_IDMK = 5'h0f, ST_IDFLG = 5'h0e,
        ST_IDB = 5'h0a, ST_ICRC = 5'h0b, ST_PIDG = 5'h09,
        ST_DSYNC = 5'h08, ST_DMK = 5'h18, ST_DFLG = 5'h19,
        ST_FILL = 5'h1b, ST_DCRC = 5'h1a, ST_PDG = 5'h1e,
        ST_TAIL = 5'h1f
    } dtf_state_e;
endpackage : dtf_pkg

/* File: testbench/dtf_drive_model.sv */
// Purpose: Drive side model: index pulse, byte requests, byte capture
// Assumes: The drive spins freely; one turn is TRACK clocks
// Notes: Captured bytes hold data in the high byte, clock pattern low
`timescale 1ns/1ps
`default_nettype none
module dtf_drive_model #(
    parameter int TRACK = 5000,
    // Sector pulse start, a multiple of 8 so no byte request lands on it
    parameter int SECTOR_AT = 2496
) (
    input wire logic clk,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] wr_clk,
    input wire logic wr_strobe,
    input wire logic wr_oe,
    output logic index_pulse,
    output logic sector_pulse,
    output logic byte_req
);
    int cnt = 0;
    logic [15:0] q [$];
    // Rotation: index high 16 clocks per turn, byte request every 8 clocks
    assign index_pulse = (cnt < 16);
    assign byte_req = cnt[2];
    // One sector pulse per turn, 16 clocks wide; only hard-sectored runs wait on it
    assign sector_pulse = (cnt >= SECTOR_AT) && (cnt < SECTOR_AT + 16);
    // Turn counter and capture of every byte strobed while wr_oe is high
    always @(posedge clk)
    begin
        cnt <= (cnt == TRACK - 1) ? 0 : cnt + 1;
        if (wr_strobe && wr_oe)
            q.push_back({wr_data, wr_clk});
    end
endmodule : dtf_drive_model
`default_nettype wire

/* File: testbench/test_disk_track_formatter.sv */
// Purpose: Self-checking bench of the disk track formatter
// Assumes: Drive model turns once every 5000 clocks
// Notes: Byte positions count from the first byte after the start index
`timescale 1ns/1ps
`default_nettype none
`include "dtf_consts.svh"
module test_disk_track_formatter;
    typedef struct {int m; int p; logic [7:0] d; logic [7:0] c;} dtf_row_s;
    logic REF_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0] PADDR, WR_DATA, WR_CLK;
    logic [31:0] PWDATA, PRDATA, rd;
    logic INDEX_PULSE, SECTOR_PULSE, BYTE_REQ, WR_STROBE, WR_OE, er;
    int miscompares = 0;
    int compares = 0;
    // Per mode: control bits, gap/length/fill word, sector count
    // Mode 3 is hard-sectored: bytes pause after the post-index gap until the sector pulse
    logic [31:0] mctl [4] = '{32'h0, 32'h4, 32'h8, 32'h18};
    logic [31:0] trkb [4] = '{32'h1b0000a5, 32'h360001a5, 32'h0f0000a5, 32'h0f0000a5};
    logic [31:0] bufl [4] = '{32'h1, 32'h1, 32'h2, 32'h1};
    // Mode, position, data, clock pattern
    dtf_row_s rows [] = '{'{0,0,8'hff,8'hff}, '{0,40,8'h00,8'hff}, '{0,46,8'hfc,8'hd7}, '{0,47,8'hff,8'hff},
        '{0,79,8'hfe,8'hc7}, '{0,80,8'h25,8'hff}, '{0,81,8'h01,8'hff}, '{0,82,8'h03,8'hff}, '{0,83,8'h00,8'hff},
        '{0,86,8'hff,8'hff}, '{0,103,8'hfb,8'hc7}, '{0,104,8'ha5,8'hff}, '{0,231,8'ha5,8'hff}, '{0,234,8'hff,8'hff},
        '{1,0,8'h4e,8'hff}, '{1,80,8'h00,8'hff}, '{1,92,8'hc2,8'hf7}, '{1,94,8'hc2,8'hf7}, '{1,95,8'hfc,8'hff},
        '{1,96,8'h4e,8'hff}, '{1,160,8'ha1,8'hef}, '{1,161,8'hfe,8'hff}, '{1,165,8'h01,8'hff}, '{1,168,8'h4e,8'hff},
        '{1,204,8'ha1,8'hef}, '{1,205,8'hfb,8'hff}, '{1,461,8'ha5,8'hff}, '{1,464,8'h4e,8'hff},
        '{2,19,8'h4e,8'hff}, '{2,20,8'h00,8'hff}, '{2,32,8'ha1,8'hef}, '{2,33,8'hfe,8'hff}, '{2,34,8'h00,8'hff},
        '{2,35,8'h25,8'hff}, '{2,37,8'h03,8'hff}, '{2,38,8'h00,8'hff}, '{2,41,8'h00,8'hff}, '{2,56,8'ha1,8'hef},
        '{2,57,8'hfb,8'hff}, '{2,185,8'ha5,8'hff}, '{2,215,8'ha1,8'hef}, '{2,220,8'h04,8'hff},
        '{3,19,8'h4e,8'hff}, '{3,20,8'h00,8'hff}, '{3,32,8'ha1,8'hef}, '{3,36,8'h01,8'hff}};

    dtf_formatter dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .INDEX_PULSE(INDEX_PULSE), .SECTOR_PULSE(SECTOR_PULSE), .BYTE_REQ(BYTE_REQ),
        .WR_DATA(WR_DATA), .WR_CLK(WR_CLK), .WR_STROBE(WR_STROBE), .WR_OE(WR_OE));
    dtf_drive_model drv (.clk(REF_CLK), .wr_data(WR_DATA), .wr_clk(WR_CLK), .wr_strobe(WR_STROBE),
        .wr_oe(WR_OE), .index_pulse(INDEX_PULSE), .sector_pulse(SECTOR_PULSE), .byte_req(BYTE_REQ));

    always #4 REF_CLK = ~REF_CLK;

    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        // No cycle limit here: only the watchdog ends a wait
        do
        begin
            @(posedge REF_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (compares > 0 && miscompares == 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // One formatted track in mode m, then its byte rows
    task automatic run_track(input int m);
        int k;
        apb(1'b1, `DTF_A_BUFL, bufl[m]);
        apb(1'b1, `DTF_A_IDW, 32'h03010025);
        apb(1'b1, `DTF_A_TRKB, trkb[m]);
        apb(1'b1, `DTF_A_CTRL, mctl[m] | 32'h1);
        drv.q.delete();
        apb(1'b1, `DTF_A_CTRL, mctl[m] | 32'h3);
        // fill changed mid-run must not show
        apb(1'b1, `DTF_A_TRKB, trkb[m] ^ 32'hff);
        k = 0;
        do
        begin
            repeat (100) @(posedge REF_CLK);
            apb(1'b0, `DTF_A_STAT, 32'h0);
            k++;
        end while (rd[`DTF_S_DONE] !== 1'b1 && k < 150);
        chk(rd & 32'hffff0006, {bufl[m][15:0], 16'h0004}); // Sectors and done
        chk({31'h0, WR_OE}, 32'h0); // Pins released after the index
        apb(1'b1, `DTF_A_STAT, 32'h4);
        foreach (rows[i])
            if (rows[i].m == m)
                chk({16'h0, drv.q[rows[i].p]}, {16'h0, rows[i].d, rows[i].c}); // Pattern
    endtask : run_track

    // Watchdog cuts a hang short
    initial
    begin
        repeat (90000) @(posedge REF_CLK);
        miscompares++;
        end_of_test();
    end

    initial
    begin
        REF_CLK = 1'b0;
        SYS_RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (3) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        for (int m = 0; m < 4; m++)
            run_track(m);
        // Hard-sectored: 20 gap bytes, then nothing until the sector pulse, then bytes to the index
        chk(drv.q.size(), 32'd333); // Bytes held back until sector pulse
        // Second reset in mid-run, then a start without host setup
        apb(1'b1, `DTF_A_CTRL, 32'h3);
        repeat (6000) @(posedge REF_CLK);
        SYS_RST <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        chk({31'h0, WR_OE}, 32'h0); // Write pins released in reset
        SYS_RST <= 1'b0;
        apb(1'b0, `DTF_A_STAT, 32'h0);
        chk(rd, 32'h0); // Status cleared
        drv.q.delete();
        apb(1'b1, `DTF_A_CTRL, 32'h2);
        repeat (11000) @(posedge REF_CLK);
        chk(drv.q.size(), 32'h0); // No bytes before setup
        apb(1'b0, `DTF_A_STAT, 32'h0);
        chk(rd & 32'h7, 32'h0); // Still idle and uninitialised
        apb(1'b0, 8'h20, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000); // Unmapped place refused
        end_of_test();
    end
endmodule : test_disk_track_formatter
`default_nettype wire
